// file: rtl/sbh_pkg.sv
// Purpose: shared constants and types of the shared bus host port
// Assumes: 50 MHz system clock, 16-bit shared bus
// Notes: host register offsets are word indices on the host command port
package sbh_pkg;
	localparam int SBH_CLK_MHZ = 50;
	// shared bus field positions
	localparam int SBH_BE_LSB = 12;
	localparam int SBH_DMA_BIT = 1;
	localparam logic [15:0] SBH_ADDR_MASK16 = 16'hF0FE;
	// rx frame pointer register in the device and its control bits
	localparam logic [7:0] SBH_RXFP_ADDR = 8'h86;
	localparam logic [15:0] SBH_RXFP_RST = 16'h0000;
	localparam int SBH_ENDIAN_BIT = 11;
	localparam int SBH_LATCH_BIT = 12;
	// synchronised pin vector {cmd, cs_n, rd_n, wr_n}
	localparam int SBH_PIN_CMD = 3;
	localparam int SBH_PIN_CS = 2;
	localparam int SBH_PIN_RD = 1;
	localparam int SBH_PIN_WR = 0;
	localparam logic [3:0] SBH_PIN_IDLE = 4'h7;
	// host strobe timing
	localparam int SBH_STROBE_NS = 160;
	localparam int SBH_RECOVER_NS = 80;
	localparam int SBH_STROBE_CYC = (SBH_STROBE_NS * SBH_CLK_MHZ + 999) / 1000;
	localparam int SBH_RECOVER_CYC = (SBH_RECOVER_NS * SBH_CLK_MHZ + 999) / 1000;
	localparam logic [3:0] SBH_STROBE_LAST = 4'(SBH_STROBE_CYC - 1);
	localparam logic [3:0] SBH_RECOVER_LAST = 4'(SBH_RECOVER_CYC - 1);
	// host command port registers
	localparam logic [7:0] SBH_H_GO = 8'h00;
	localparam logic [7:0] SBH_H_WDATA = 8'h01;
	localparam logic [7:0] SBH_H_RDATA = 8'h02;
	localparam logic [7:0] SBH_H_STATUS = 8'h03;
	localparam logic [7:0] SBH_H_CFG = 8'h04;
	localparam int SBH_GO_CMD = 0;
	localparam int SBH_GO_READ = 1;
	localparam int SBH_CFG_BUS16 = 0;
	localparam int SBH_CFG_CS_TIE = 1;
	localparam logic [1:0] SBH_CFG_RST = 2'h1;
	typedef enum logic [1:0] {SBH_H_IDLE, SBH_H_STROBE, SBH_H_RECOVER} sbh_hstate_type;
endpackage

// file: rtl/sbh_if.sv
// Purpose: pins between the host and the device shared bus port
// Assumes: each end drives the shared bus only with its enable low
// Notes: an undriven bus reads as zero
`timescale 1ns/1ns
interface sbh_if;
	logic [15:0] shared_bus;
	logic [15:0] sd_host_out;
	logic sd_host_oe_n;
	logic [15:0] sd_dev_out;
	logic sd_dev_oe_n;
	logic cmd;
	logic chip_select_n;
	logic read_strobe_n;
	logic write_strobe_n;
	logic irq_n;
	assign shared_bus = !sd_dev_oe_n ? sd_dev_out : (!sd_host_oe_n ? sd_host_out : 16'h0000);
	modport device(input shared_bus, cmd, chip_select_n, read_strobe_n, write_strobe_n,
		output sd_dev_out, sd_dev_oe_n, irq_n);
	modport host(input shared_bus, irq_n,
		output sd_host_out, sd_host_oe_n, cmd, chip_select_n, read_strobe_n, write_strobe_n);
endinterface

// file: rtl/sbh_host.sv
// Purpose: host end that runs shared bus cycles on command
// Assumes: device answers within the strobe time
// Notes: a go write while busy is ignored
`timescale 1ns/1ns
module sbh_host (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	sbh_if.host bus,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out
);
	typedef struct packed {
		sbh_pkg::sbh_hstate_type st;
		logic [3:0] cnt;
		logic is_read;
		logic [1:0] cfg;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [15:0] port_rdata;
		logic irq_s;
		logic [15:0] sd_out;
		logic oe_n;
		logic cmd;
		logic cs_n;
		logic rd_n;
		logic wr_n;
	} sbh_host_state_type;

	sbh_host_state_type r;
	sbh_host_state_type n;
	logic bus16;
	logic go;

	assign bus16 = r.cfg[sbh_pkg::SBH_CFG_BUS16];
	assign go = wr_in && addr_in == sbh_pkg::SBH_H_GO && r.st == sbh_pkg::SBH_H_IDLE;

	always_comb begin
		n = r;
		n.irq_s = !bus.irq_n;
		n.port_rdata = 16'h0000;
		if (rd_in) begin
			unique case (addr_in)
				sbh_pkg::SBH_H_WDATA: n.port_rdata = r.wdata;
				sbh_pkg::SBH_H_RDATA: n.port_rdata = r.rdata;
				sbh_pkg::SBH_H_STATUS: n.port_rdata = {14'h0000, r.irq_s, r.st != sbh_pkg::SBH_H_IDLE};
				sbh_pkg::SBH_H_CFG: n.port_rdata = {14'h0000, r.cfg};
				default: n.port_rdata = 16'h0000;
			endcase
		end
		if (wr_in && addr_in == sbh_pkg::SBH_H_WDATA) begin
			n.wdata = wdata_in;
		end
		if (wr_in && addr_in == sbh_pkg::SBH_H_CFG) begin
			n.cfg = wdata_in[1:0];
		end
		unique case (r.st)
			sbh_pkg::SBH_H_IDLE: begin
				n.cs_n = !r.cfg[sbh_pkg::SBH_CFG_CS_TIE];
				if (go) begin
					// address first with cmd high, then data with cmd low
					n.cmd = wdata_in[sbh_pkg::SBH_GO_CMD];
					n.is_read = wdata_in[sbh_pkg::SBH_GO_READ];
					n.cs_n = 1'b0;
					n.rd_n = !wdata_in[sbh_pkg::SBH_GO_READ];
					n.wr_n = wdata_in[sbh_pkg::SBH_GO_READ];
					n.oe_n = wdata_in[sbh_pkg::SBH_GO_READ];
					// 8-bit mode keeps the upper lines low
					n.sd_out = bus16 ? r.wdata : {8'h00, r.wdata[7:0]};
					n.cnt = sbh_pkg::SBH_STROBE_LAST;
					n.st = sbh_pkg::SBH_H_STROBE;
				end
			end
			sbh_pkg::SBH_H_STROBE: begin
				n.cnt = r.cnt - 4'h1;
				if (r.cnt == 4'h0) begin
					n.rd_n = 1'b1;
					n.wr_n = 1'b1;
					if (r.is_read) begin
						// read data taken at the rising strobe
						n.rdata = bus16 ? bus.shared_bus : {8'h00, bus.shared_bus[7:0]};
					end
					n.cnt = sbh_pkg::SBH_RECOVER_LAST;
					n.st = sbh_pkg::SBH_H_RECOVER;
				end
			end
			sbh_pkg::SBH_H_RECOVER: begin
				n.oe_n = 1'b1;
				n.sd_out = 16'h0000;
				n.cs_n = !r.cfg[sbh_pkg::SBH_CFG_CS_TIE];
				n.cnt = r.cnt - 4'h1;
				if (r.cnt == 4'h0) begin
					n.st = sbh_pkg::SBH_H_IDLE;
				end
			end
			default: n.st = sbh_pkg::SBH_H_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
			r.cfg <= sbh_pkg::SBH_CFG_RST;
			r.oe_n <= 1'b1;
			r.cs_n <= 1'b1;
			r.rd_n <= 1'b1;
			r.wr_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign rdata_out = r.port_rdata;
	assign bus.sd_host_out = r.sd_out;
	assign bus.sd_host_oe_n = r.oe_n;
	assign bus.cmd = r.cmd;
	assign bus.chip_select_n = r.cs_n;
	assign bus.read_strobe_n = r.rd_n;
	assign bus.write_strobe_n = r.wr_n;
endmodule // sbh_host

// file: rtl/sbh_device.sv
// Purpose: device end of the shared bus host port
// Assumes: strobes asynchronous, resampled on sys_clk_in
// Notes: register data port answers in the same cycle as reg_rd_out
// What this block does
// - cmd high write captures address and enables
// - 16-bit address on bits 7-2, enables 15-12
// - 8-bit address on low eight lines
// - host holds upper lines low in 8-bit
// - cmd low reads drive, writes accept data
// - cmd high read returns stored address word
// - nothing happens without chip select low
// - host holds strobe low whole cycle
// - interrupt output low while condition present
// - read data held until strobe rises
// - pointer bit 12 selects write latch moment
// - 16-bit bus bytes or words, 8-bit bytes
// - strap pulled up selects big endian
// - pointer bit 11 selects byte order otherwise
// - byte swapping done inside the device
// - single or burst accesses, byte or word
// - host sets bus bit one for dma, 16-bit bus only
// - host writes address then accesses data
// - chip select may be tied low
// - cmd may come from host address bit
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module sbh_device (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	sbh_if.device bus,
	input wire logic bus16_in,
	input wire logic endian_strap_in,
	input wire logic irq_cond_in,
	output logic [7:0] reg_addr_out,
	output logic [3:0] reg_be_out,
	output logic reg_wr_out,
	output logic [15:0] reg_wdata_out,
	output logic reg_rd_out,
	input wire logic [15:0] reg_rdata_in,
	output logic endian_big_out,
	output logic dma_flag_out
);
	typedef struct packed {
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
		logic [3:0] pin_d;
		logic [15:0] bus_s1;
		logic [15:0] bus_s2;
		logic [15:0] wr_hold;
		logic wr_act;
		logic wr_cmd;
		logic rd_wait;
		logic [15:0] addr_word;
		logic [15:0] rxfp;
		logic [7:0] reg_addr;
		logic [3:0] reg_be;
		logic reg_wr;
		logic [15:0] reg_wdata;
		logic reg_rd;
		logic dma;
		logic [15:0] sd_out;
		logic sd_oe_n;
		logic irq_n;
		logic endian_big;
	} sbh_dev_state_type;

	sbh_dev_state_type r;
	sbh_dev_state_type n;
	logic sel;
	logic wr_fall;
	logic wr_rise;
	logic rd_fall;
	logic rd_end;
	logic early;
	logic do_commit;
	logic c_cmd;
	logic [15:0] c_data;
	logic swap;
	logic [15:0] wd;
	logic lane_lo;
	logic lane_hi;
	logic at_rxfp;

	// byte order and lane of a value returned on the bus
	function automatic logic [15:0] fmt(input logic [15:0] v, input logic b16, input logic sw,
		input logic hi);
		if (b16) begin
			fmt = sw ? {v[7:0], v[15:8]} : v;
		end else begin
			fmt = {8'h00, hi ? v[15:8] : v[7:0]};
		end
	endfunction

	assign sel = !r.pin_s2[sbh_pkg::SBH_PIN_CS];
	assign wr_fall = sel && r.pin_d[sbh_pkg::SBH_PIN_WR] && !r.pin_s2[sbh_pkg::SBH_PIN_WR];
	assign wr_rise = !r.pin_d[sbh_pkg::SBH_PIN_WR] && r.pin_s2[sbh_pkg::SBH_PIN_WR];
	assign rd_fall = sel && r.pin_d[sbh_pkg::SBH_PIN_RD] && !r.pin_s2[sbh_pkg::SBH_PIN_RD];
	assign rd_end = r.pin_s2[sbh_pkg::SBH_PIN_RD] || r.pin_s2[sbh_pkg::SBH_PIN_CS];
	// latch at strobe assertion when set, at strobe release when clear
	assign early = r.rxfp[sbh_pkg::SBH_LATCH_BIT];
	assign do_commit = (wr_fall && early) || (wr_rise && r.wr_act && !early);
	assign c_cmd = wr_fall ? r.pin_s2[sbh_pkg::SBH_PIN_CMD] : r.wr_cmd;
	assign c_data = wr_fall ? r.bus_s2 : r.wr_hold;
	assign swap = r.endian_big && bus16_in;
	// 8-bit writes replicate the byte on both lanes
	assign wd = bus16_in ? (swap ? {c_data[7:0], c_data[15:8]} : c_data)
		: {c_data[7:0], c_data[7:0]};
	assign lane_lo = r.reg_be[0] || r.reg_be[2];
	assign lane_hi = r.reg_be[1] || r.reg_be[3];
	// the pointer fills byte lanes 2 and 3 of its word, reached in either bus width
	assign at_rxfp = r.reg_addr[7:2] == sbh_pkg::SBH_RXFP_ADDR[7:2] && (r.reg_be[2] || r.reg_be[3]);

	always_comb begin
		n = r;
		// two flop resampling of pins, bus data kept aligned with them
		n.pin_s1 = {bus.cmd, bus.chip_select_n, bus.read_strobe_n, bus.write_strobe_n};
		n.pin_s2 = r.pin_s1;
		n.pin_d = r.pin_s2;
		n.bus_s1 = bus.shared_bus;
		n.bus_s2 = r.bus_s1;
		n.reg_wr = 1'b0;
		n.reg_rd = 1'b0;
		n.rd_wait = 1'b0;
		n.irq_n = !irq_cond_in;
		n.endian_big = endian_strap_in || r.rxfp[sbh_pkg::SBH_ENDIAN_BIT];
		if (wr_fall) begin
			n.wr_act = 1'b1;
			n.wr_cmd = r.pin_s2[sbh_pkg::SBH_PIN_CMD];
			n.wr_hold = r.bus_s2;
		end else if (r.wr_act && !r.pin_s2[sbh_pkg::SBH_PIN_WR]) begin
			n.wr_hold = r.bus_s2;
		end
		if (wr_rise) begin
			n.wr_act = 1'b0;
		end
		if (do_commit && c_cmd) begin
			// address phase; held for every following data access
			n.addr_word = bus16_in ? (c_data & sbh_pkg::SBH_ADDR_MASK16) : {8'h00, c_data[7:0]};
			if (bus16_in) begin
				n.reg_addr = {c_data[7:2], 2'h0};
				n.reg_be = c_data[15:sbh_pkg::SBH_BE_LSB];
			end else begin
				n.reg_addr = c_data[7:0];
				n.reg_be = 4'h1 << c_data[1:0];
			end
			n.dma = bus16_in && c_data[sbh_pkg::SBH_DMA_BIT];
		end else if (do_commit) begin
			// data phase write, single or one beat of a burst
			if (at_rxfp) begin
				if (lane_lo) begin
					n.rxfp[7:0] = wd[7:0];
				end
				if (lane_hi) begin
					n.rxfp[15:8] = wd[15:8];
				end
			end else begin
				n.reg_wdata = wd;
				n.reg_wr = 1'b1;
			end
		end
		if (rd_fall) begin
			if (r.pin_s2[sbh_pkg::SBH_PIN_CMD]) begin
				n.sd_out = bus16_in ? r.addr_word : {8'h00, r.addr_word[7:0]};
				n.sd_oe_n = 1'b0;
			end else if (at_rxfp) begin
				n.sd_out = fmt(r.rxfp, bus16_in, swap, r.reg_addr[0]);
				n.sd_oe_n = 1'b0;
			end else begin
				n.reg_rd = 1'b1;
				n.rd_wait = 1'b1;
			end
		end else if (r.rd_wait) begin
			n.sd_out = fmt(reg_rdata_in, bus16_in, swap, r.reg_addr[0]);
			n.sd_oe_n = rd_end;
		end else if (rd_end) begin
			// drive kept until the strobe or chip select is seen high
			n.sd_oe_n = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
			r.pin_s1 <= sbh_pkg::SBH_PIN_IDLE;
			r.pin_s2 <= sbh_pkg::SBH_PIN_IDLE;
			r.pin_d <= sbh_pkg::SBH_PIN_IDLE;
			r.rxfp <= sbh_pkg::SBH_RXFP_RST;
			r.sd_oe_n <= 1'b1;
			r.irq_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign reg_addr_out = r.reg_addr;
	assign reg_be_out = r.reg_be;
	assign reg_wr_out = r.reg_wr;
	assign reg_wdata_out = r.reg_wdata;
	assign reg_rd_out = r.reg_rd;
	assign endian_big_out = r.endian_big;
	assign dma_flag_out = r.dma;
	assign bus.sd_dev_out = r.sd_out;
	assign bus.sd_dev_oe_n = r.sd_oe_n;
	assign bus.irq_n = r.irq_n;
endmodule // sbh_device

// file: bench/sbh_asserts.sv
// Purpose: interface checks for the shared bus host port
// Assumes: one clock domain, reset active low
// Notes: sees only the wires between the two ends
`timescale 1ns/1ns
module sbh_asserts (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic [15:0] shared_bus,
	input wire logic [15:0] sd_host_out,
	input wire logic sd_host_oe_n,
	input wire logic [15:0] sd_dev_out,
	input wire logic sd_dev_oe_n,
	input wire logic cmd,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic irq_n
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence wr_held;
		(!write_strobe_n)[*8] ##1 write_strobe_n;
	endsequence
	sequence rd_held;
		(!read_strobe_n)[*8] ##1 read_strobe_n;
	endsequence
	chk_one_driver: assert property (sd_dev_oe_n || sd_host_oe_n)
		else $error("both ends drive the bus");
	chk_drive_cause: assert property (!sd_dev_oe_n |-> $past(!chip_select_n && !read_strobe_n, 3))
		else $error("device drives without a selected read");
	chk_answer_time: assert property ($fell(read_strobe_n) && !chip_select_n |-> ##[3:5] !sd_dev_oe_n)
		else $error("read not answered in time");
	chk_hold_to_rise: assert property ($rose(read_strobe_n) |-> !sd_dev_oe_n)
		else $error("read data gone before strobe rise");
	chk_release_bound: assert property ($rose(read_strobe_n) |-> ##[1:4] sd_dev_oe_n)
		else $error("device holds bus too long");
	chk_data_steady: assert property (!sd_dev_oe_n && $past(!sd_dev_oe_n) && !read_strobe_n |-> $stable(sd_dev_out))
		else $error("read data moved under strobe");
	chk_quiet_write: assert property (!write_strobe_n |-> sd_dev_oe_n && !sd_host_oe_n)
		else $error("wrong driver during write");
	chk_strobe_cs: assert property (!read_strobe_n || !write_strobe_n |-> !chip_select_n)
		else $error("strobe without chip select");
	chk_write_len: assert property ($fell(write_strobe_n) |-> wr_held)
		else $error("write strobe length wrong");
	chk_read_len: assert property ($fell(read_strobe_n) |-> rd_held)
		else $error("read strobe length wrong");
	chk_write_stable: assert property (!write_strobe_n && $past(!write_strobe_n) |-> $stable(shared_bus) && $stable(cmd))
		else $error("write value moved under strobe");
endmodule // sbh_asserts

// file: bench/test_async_shared_bus_host_port.sv
// Purpose: self-checking bench for the shared bus host port
// Assumes: all bus traffic is started through the host command port
// Notes: the device register side is answered by the bench
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("[FAIL] %0t line %0d got %h exp %h", $time, `__LINE__, a, e); end end
module test_async_shared_bus_host_port;
	logic sys_clk_in, nrst_in, wr_in, rd_in, bus16_in, endian_strap_in, irq_cond_in;
	logic reg_wr_out, reg_rd_out, endian_big_out, dma_flag_out;
	logic [7:0] addr_in, reg_addr_out;
	logic [15:0] wdata_in, rdata_out, reg_wdata_out, reg_rdata_in, wlast;
	logic [3:0] reg_be_out;
	int checks = 0, fails = 0, wcnt = 0, rcnt = 0;
	sbh_if sbh_if_inst();
	sbh_host sbh_host_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .bus(sbh_if_inst.host), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
	sbh_device sbh_device_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .bus(sbh_if_inst.device),
		.bus16_in(bus16_in), .endian_strap_in(endian_strap_in), .irq_cond_in(irq_cond_in),
		.reg_addr_out(reg_addr_out), .reg_be_out(reg_be_out), .reg_wr_out(reg_wr_out), .reg_wdata_out(reg_wdata_out),
		.reg_rd_out(reg_rd_out), .reg_rdata_in(reg_rdata_in), .endian_big_out(endian_big_out),
		.dma_flag_out(dma_flag_out));
	sbh_asserts sbh_asserts_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .shared_bus(sbh_if_inst.shared_bus),
		.sd_host_out(sbh_if_inst.sd_host_out), .sd_host_oe_n(sbh_if_inst.sd_host_oe_n),
		.sd_dev_out(sbh_if_inst.sd_dev_out), .sd_dev_oe_n(sbh_if_inst.sd_dev_oe_n), .cmd(sbh_if_inst.cmd),
		.chip_select_n(sbh_if_inst.chip_select_n), .read_strobe_n(sbh_if_inst.read_strobe_n),
		.write_strobe_n(sbh_if_inst.write_strobe_n), .irq_n(sbh_if_inst.irq_n));
	initial begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end
	// records what the device hands to its register side
	always @(posedge sys_clk_in) begin
		if (reg_wr_out === 1'b1) begin
			wcnt <= wcnt + 1;
			wlast <= reg_wdata_out;
		end
		if (reg_rd_out === 1'b1) rcnt <= rcnt + 1;
	end
	task automatic final_report();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic reset_dut();
		@(posedge sys_clk_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
	endtask
	task automatic hw(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic hr(input logic [7:0] a, output logic [15:0] v);
		@(posedge sys_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge sys_clk_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask
	// one bus cycle on the shared bus, waits for the host to go idle
	task automatic op(input logic c, input logic r, input logic [15:0] d, output logic [15:0] v);
		logic [15:0] s;
		int n;
		hw(sbh_pkg::SBH_H_WDATA, d);
		hw(sbh_pkg::SBH_H_GO, {14'h0000, r, c});
		n = 0;
		s = 16'h0001;
		while (s[0] !== 1'b0 && n < 40) begin
			hr(sbh_pkg::SBH_H_STATUS, s);
			n++;
		end
		`CHK(s[0], 1'b0)
		hr(sbh_pkg::SBH_H_RDATA, v);
	endtask
	task automatic t_addr();
		logic [15:0] v;
		op(1'b1, 1'b0, 16'hF342, v);
		`CHK(reg_addr_out, 8'h40)
		`CHK(reg_be_out, 4'hF)
		`CHK(dma_flag_out, 1'b1)
		op(1'b1, 1'b1, 16'h0000, v);
		`CHK(v, 16'hF042)
	endtask
	task automatic t_data();
		logic [15:0] v;
		int w0;
		w0 = wcnt;
		op(1'b0, 1'b0, 16'h1234, v);
		`CHK(wcnt, w0 + 1)
		`CHK(wlast, 16'h1234)
		op(1'b0, 1'b0, 16'hABCD, v);
		`CHK(wlast, 16'hABCD)
		`CHK(reg_addr_out, 8'h40)
		w0 = rcnt;
		op(1'b0, 1'b1, 16'h0000, v);
		`CHK(v, 16'hBEEF)
		`CHK(rcnt, w0 + 1)
	endtask
	task automatic t_endian();
		logic [15:0] v;
		int w0;
		@(posedge sys_clk_in);
		endian_strap_in <= 1'b1;
		op(1'b0, 1'b0, 16'h1234, v);
		`CHK(endian_big_out, 1'b1)
		`CHK(wlast, 16'h3412)
		op(1'b0, 1'b1, 16'h0000, v);
		`CHK(v, 16'hEFBE)
		@(posedge sys_clk_in);
		endian_strap_in <= 1'b0;
		op(1'b1, 1'b0, 16'hC084, v);
		w0 = wcnt;
		op(1'b0, 1'b0, 16'h1800, v);
		`CHK(wcnt, w0)
		`CHK(endian_big_out, 1'b1)
		op(1'b0, 1'b1, 16'h0000, v);
		`CHK(v, 16'h0018)
		op(1'b1, 1'b0, 16'hF040, v);
		`CHK(reg_addr_out, 8'h40)
		op(1'b0, 1'b0, 16'h5678, v);
		`CHK(wlast, 16'h7856)
	endtask
	task automatic t_irq();
		logic [15:0] v;
		@(posedge sys_clk_in);
		irq_cond_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		hr(sbh_pkg::SBH_H_STATUS, v);
		`CHK(v[1], 1'b1)
		`CHK(sbh_if_inst.irq_n, 1'b0)
		@(posedge sys_clk_in);
		irq_cond_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		hr(sbh_pkg::SBH_H_STATUS, v);
		`CHK(v[1], 1'b0)
	endtask
	task automatic t_byte();
		logic [15:0] v;
		reset_dut();
		bus16_in <= 1'b0;
		hw(sbh_pkg::SBH_H_CFG, 16'h0000);
		op(1'b1, 1'b0, 16'h0045, v);
		`CHK(reg_addr_out, 8'h45)
		`CHK(reg_be_out, 4'h2)
		op(1'b1, 1'b1, 16'h0000, v);
		`CHK(v, 16'h0045)
		op(1'b0, 1'b0, 16'h005A, v);
		`CHK(wlast, 16'h5A5A)
		op(1'b0, 1'b1, 16'h0000, v);
		`CHK(v, 16'h00BE)
	endtask
	initial begin
		nrst_in = 1'b0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 8'h00;
		wdata_in = 16'h0000;
		bus16_in = 1'b1;
		endian_strap_in = 1'b0;
		irq_cond_in = 1'b0;
		reg_rdata_in = 16'hBEEF;
		reset_dut();
		t_addr();
		t_data();
		t_endian();
		t_irq();
		t_byte();
		final_report();
	end
	initial begin
		#200000;
		fails++;
		final_report();
	end
endmodule // test_async_shared_bus_host_port
